/* verilog/fsw_pkg.sv */
// package for the fail-safe watchdog unit: register map, fields, timing
package fsw_pkg;
    // ==========================================================
    // register byte offsets (word aligned)
    localparam logic [7:0] FSW_OFF_RELOAD = 8'h00;
    localparam logic [7:0] FSW_OFF_CTRL = 8'h04;
    localparam logic [7:0] FSW_OFF_STATUS = 8'h08;
    localparam logic [7:0] FSW_OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] FSW_OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] FSW_OFF_COUNT = 8'h14;
    // ==========================================================
    // control register bits
    localparam int FSW_CTRL_REFRESH = 0;
    localparam int FSW_CTRL_START = 1;
    localparam int FSW_CTRL_IDLE = 2;
    localparam int FSW_CTRL_PDOWN = 3;
    // reload register: bit 7 selects prescaler, bits 6:0 reload value
    localparam int FSW_REL_PSEL = 7;
    // status register bits
    localparam int FSW_ST_CAUSE = 0;
    localparam int FSW_ST_RUN = 1;
    localparam int FSW_ST_OSC_RST = 2;
    localparam int FSW_ST_RC_CLK = 3;
    // interrupt status bits
    localparam int FSW_IRQ_WDOVF = 0;
    localparam int FSW_IRQ_OSCFAIL = 1;
    localparam int FSW_IRQ_WAKE = 2;
    localparam int FSW_IRQ_W = 3;
    // ==========================================================
    // counter shape and prescale ratios in oscillator clocks
    localparam int FSW_CNT_W = 15;
    localparam int FSW_REL_W = 7;
    localparam int FSW_DIV_SLOW = 192;
    localparam int FSW_DIV_FAST = 12;
    localparam int FSW_DIV_W = 8;
    // final reset phase and wake-up interrupt vector
    localparam int FSW_CLK_MHZ = 40;
    localparam int FSW_FINAL_US = 1000;
    localparam int FSW_FINAL_CYC = FSW_FINAL_US * FSW_CLK_MHZ;
    localparam logic [15:0] FSW_WAKE_VECTOR = 16'h007B;
    // ==========================================================
    typedef struct packed {
        logic htrans_nonseq;
        logic hwrite;
        logic [7:0] addr;
    } fsw_req_t;
    typedef enum logic [1:0] {FSW_OSC_RESET, FSW_OSC_SETTLE, FSW_OSC_RUN, FSW_OSC_STOP} fsw_osc_t;
endpackage : fsw_pkg

/* verilog/fsw_top.sv */
// fail-safe watchdog unit: software watchdog and oscillator monitor behind AHB-Lite
// ==========================================================
// How it works
// R1: 15-bit counter counts prescaled oscillator clock
// R2: prescale select gives osc/12 or osc/192
// R3: software programs upper seven counter bits
// R4: start bit runs watchdog; no software stop
// R5: overflow forces internal reset
// R6: refresh loads reload value into upper bits
// R7: software refreshes with refresh then start
// R8: reset-cause flag readable by software
// R9: counter frozen in idle and power-down
// R10: slow main oscillator: RC clock, hold reset
// R11: about 1 ms final reset after recovery
// R12: power-on reset sequenced by monitor same way
// R13: power-down stops oscillators; wake restarts them
// R14: wake resumes after oscillator good plus 1 ms
// R15: wake raises wake-up interrupt at its vector
// R16: reset clears state; wake keeps it
// R17: refresh only when start write follows directly
// R18: overflow sets cause flag; external reset clears
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fsw_top
    import fsw_pkg::*;
#(
    parameter int FINAL_CYC = FSW_FINAL_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic MAIN_OSC_SLOW,
    input wire logic EXT_IRQ0_PIN_N,
    input wire logic USB_ACTIVITY,
    output logic OSC_STOP,
    output logic RC_CLK_SEL,
    output logic INT_RESET,
    output logic WAKE_IRQ,
    output logic [15:0] WAKE_VECTOR,
    output logic IRQ
);
    // ==========================================================
    // bus address phase capture
    fsw_req_t req_q, req_d;
    logic [7:0] reload_q, reload_d;
    logic [FSW_CNT_W-1:0] cnt_q, cnt_d;
    logic [FSW_DIV_W-1:0] div_q, div_d;
    logic run_q, run_d, cause_q, cause_d, arm_q, arm_d;
    logic idle_q, idle_d, pdown_q, pdown_d;
    logic [FSW_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
    logic [31:0] hrdata_d;
    logic wr, rd, tick, ovf, wd_rst_q, wd_rst_d;
    logic [FSW_DIV_W-1:0] div_max;
    logic [31:0] st_word;

    always_comb begin
        req_d = '{htrans_nonseq: 1'b0, hwrite: 1'b0, addr: 8'h00};
        if (HSEL && HREADY && HTRANS[1]) begin
            req_d = '{htrans_nonseq: 1'b1, hwrite: HWRITE, addr: HADDR[7:0]};
        end
    end
    assign wr = req_q.htrans_nonseq && req_q.hwrite;
    // reads answer in their data phase, so they decode the address phase itself
    assign rd = HSEL && HREADY && HTRANS[1] && !HWRITE;

    // ==========================================================
    // watchdog counter
    assign div_max = wd_sel() ? FSW_DIV_W'(FSW_DIV_SLOW - 1) : FSW_DIV_W'(FSW_DIV_FAST - 1); // [R2]
    function automatic logic wd_sel();
        return reload_q[FSW_REL_PSEL];
    endfunction : wd_sel
    // active mode only; the oscillator monitor reset also freezes it
    assign tick = run_q && !idle_q && !pdown_q && !INT_RESET && (div_q == div_max); // [R9]
    assign ovf = tick && (&cnt_q); // [R5]

    always_comb begin
        reload_d = reload_q;
        run_d = run_q;
        arm_d = 1'b0;
        idle_d = idle_q;
        pdown_d = pdown_q;
        imask_d = imask_q;
        cnt_d = cnt_q;
        cause_d = cause_q;
        wd_rst_d = ovf; // [R5]
        div_d = (run_q && !idle_q && !pdown_q && !INT_RESET) ? ((div_q == div_max) ? '0 : div_q + 1'b1) : div_q;
        if (tick) begin
            cnt_d = cnt_q + 1'b1; // [R1]
        end
        if (wr && req_q.addr == FSW_OFF_RELOAD) begin
            reload_d = HWDATA[7:0]; // [R3]
        end
        if (wr && req_q.addr == FSW_OFF_IRQ_MASK) begin
            imask_d = HWDATA[FSW_IRQ_W-1:0];
        end
        if (wr && req_q.addr == FSW_OFF_CTRL) begin
            // refresh bit arms; a start write as the very next bus transfer (read or write) completes it
            arm_d = HWDATA[FSW_CTRL_REFRESH] && !HWDATA[FSW_CTRL_START]; // [R17]
            if (HWDATA[FSW_CTRL_START]) begin
                run_d = 1'b1; // [R4]
                if (arm_q) begin
                    cnt_d = {reload_q[FSW_REL_W-1:0], {(FSW_CNT_W-FSW_REL_W){1'b0}}}; // [R6] [R7]
                    div_d = '0;
                end
            end
            idle_d = HWDATA[FSW_CTRL_IDLE];
            pdown_d = HWDATA[FSW_CTRL_PDOWN];
        end else if (wr) begin
            arm_d = 1'b0; // [R17]
        end else begin
            arm_d = arm_q && !req_q.htrans_nonseq;
        end
        if (pdown_q && (!EXT_IRQ0_PIN_N || USB_ACTIVITY)) begin
            pdown_d = 1'b0; // [R13]
        end
        if (idle_q && IRQ) begin
            idle_d = 1'b0;
        end
        if (ovf) begin
            cause_d = 1'b1; // [R18]
            run_d = 1'b0;
            cnt_d = '0;
            reload_d = '0;
            idle_d = 1'b0;
            pdown_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            req_q <= '{htrans_nonseq: 1'b0, hwrite: 1'b0, addr: 8'h00};
            reload_q <= '0; // [R16]
            cnt_q <= '0;
            div_q <= '0;
            run_q <= 1'b0;
            arm_q <= 1'b0;
            cause_q <= 1'b0; // [R18]
            idle_q <= 1'b0;
            pdown_q <= 1'b0;
            imask_q <= '0;
            wd_rst_q <= 1'b0;
        end else begin
            req_q <= req_d;
            reload_q <= reload_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            run_q <= run_d;
            arm_q <= arm_d;
            cause_q <= cause_d;
            idle_q <= idle_d;
            pdown_q <= pdown_d;
            imask_q <= imask_d;
            wd_rst_q <= wd_rst_d;
        end
    end

    // ==========================================================
    // oscillator monitor
    fsw_osc_t osc_q, osc_d;
    logic [31:0] tmr_q, tmr_d;
    logic wake_pend_q, wake_pend_d, wake_ev, fail_ev;
    always_comb begin
        osc_d = osc_q;
        tmr_d = tmr_q;
        wake_pend_d = wake_pend_q;
        wake_ev = 1'b0;
        fail_ev = 1'b0;
        unique case (osc_q)
            FSW_OSC_RESET: begin
                tmr_d = '0;
                if (!MAIN_OSC_SLOW) begin
                    osc_d = FSW_OSC_SETTLE; // [R10] [R12]
                end
            end
            FSW_OSC_SETTLE: begin
                tmr_d = tmr_q + 1'b1;
                if (MAIN_OSC_SLOW) begin
                    osc_d = FSW_OSC_RESET;
                end else if (tmr_q == 32'(FINAL_CYC - 1)) begin
                    osc_d = FSW_OSC_RUN; // [R11] [R14]
                    wake_ev = wake_pend_q; // [R15]
                    wake_pend_d = 1'b0;
                end
            end
            FSW_OSC_RUN: begin
                if (pdown_q) begin
                    osc_d = FSW_OSC_STOP; // [R13]
                end else if (MAIN_OSC_SLOW) begin
                    osc_d = FSW_OSC_RESET; // [R10]
                    fail_ev = 1'b1;
                end
            end
            FSW_OSC_STOP: begin
                tmr_d = '0;
                if (!pdown_q) begin
                    osc_d = FSW_OSC_RESET; // [R14]
                    wake_pend_d = 1'b1;
                end
            end
        endcase
    end

    // ==========================================================
    // interrupt status, cleared by read, set wins
    always_comb begin
        ist_d = ist_q;
        if (rd && HADDR[7:0] == FSW_OFF_IRQ_STAT) begin
            ist_d = '0;
        end
        ist_d[FSW_IRQ_WDOVF] = ist_d[FSW_IRQ_WDOVF] | ovf;
        ist_d[FSW_IRQ_OSCFAIL] = ist_d[FSW_IRQ_OSCFAIL] | fail_ev;
        ist_d[FSW_IRQ_WAKE] = ist_d[FSW_IRQ_WAKE] | wake_ev;
    end

    assign st_word = {28'h0000000, (osc_q == FSW_OSC_RESET), INT_RESET, run_q, cause_q}; // [R8]
    always_comb begin
        hrdata_d = 32'h00000000;
        if (rd) begin
            unique case (HADDR[7:0])
                FSW_OFF_RELOAD: hrdata_d = {24'h000000, reload_q};
                FSW_OFF_CTRL: hrdata_d = {28'h0000000, pdown_q, idle_q, run_q, 1'b0};
                FSW_OFF_STATUS: hrdata_d = st_word;
                FSW_OFF_IRQ_STAT: hrdata_d = {29'h00000000, ist_q};
                FSW_OFF_IRQ_MASK: hrdata_d = {29'h00000000, imask_q};
                FSW_OFF_COUNT: hrdata_d = {17'h00000, cnt_q};
                default: hrdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            osc_q <= FSW_OSC_RESET; // [R12]
            tmr_q <= '0;
            wake_pend_q <= 1'b0;
            ist_q <= '0;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            OSC_STOP <= 1'b0;
            RC_CLK_SEL <= 1'b1;
            INT_RESET <= 1'b1;
            WAKE_IRQ <= 1'b0;
            WAKE_VECTOR <= FSW_WAKE_VECTOR;
            IRQ <= 1'b0;
        end else begin
            osc_q <= osc_d;
            tmr_q <= tmr_d;
            wake_pend_q <= wake_pend_d;
            ist_q <= ist_d;
            HRDATA <= hrdata_d;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            OSC_STOP <= (osc_d == FSW_OSC_STOP); // [R13]
            RC_CLK_SEL <= (osc_d == FSW_OSC_RESET); // [R10]
            // power-on and wake go through settle; wake keeps register state
            INT_RESET <= wd_rst_d ||
                ((osc_d == FSW_OSC_RESET || osc_d == FSW_OSC_SETTLE) && !wake_pend_d); // [R5] [R16]
            WAKE_IRQ <= wake_ev; // [R15]
            WAKE_VECTOR <= FSW_WAKE_VECTOR;
            IRQ <= |(ist_d & imask_q);
        end
    end

    // ==========================================================
    a_ovf_sets_cause: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R18]
        ovf |=> cause_q && INT_RESET) else $error("overflow did not set cause and reset");
    a_run_sticks: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R4]
        run_q && !ovf |=> run_q) else $error("watchdog stopped without overflow");
    a_count_step: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R1]
        tick && !ovf && !(wr && req_q.addr == FSW_OFF_CTRL) |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("counter did not step");
    a_frozen_idle: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R9]
        (idle_q || pdown_q) && !wr |=> $stable(cnt_q)) else $error("counter moved in idle");
    a_lone_refresh: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R17]
        !arm_q && !tick && !ovf |=> $stable(cnt_q)) else $error("counter changed");
    a_refresh_load: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R6]
        wr && req_q.addr == FSW_OFF_CTRL && HWDATA[FSW_CTRL_START] && arm_q && !ovf
        |=> cnt_q[14:8] == $past(reload_q[6:0]) && cnt_q[7:0] == 8'h00) else $error("refresh load wrong");
    a_slow_holds_reset: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R10]
        osc_q == FSW_OSC_RUN && MAIN_OSC_SLOW && !pdown_q |=> RC_CLK_SEL && INT_RESET) else $error("no osc reset");
    a_settle_min: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R11]
        osc_q == FSW_OSC_RUN && $past(osc_q) == FSW_OSC_SETTLE |-> $past(tmr_q) == 32'(FINAL_CYC - 1))
        else $error("settle short");
    a_wake_irq: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R15]
        WAKE_IRQ |-> WAKE_VECTOR == FSW_WAKE_VECTOR && !INT_RESET && osc_q == FSW_OSC_RUN)
        else $error("bad wake irq");
    a_stop_osc: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R13]
        osc_q == FSW_OSC_STOP |-> OSC_STOP) else $error("oscillators not stopped");
    a_wake_exit: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R13]
        pdown_q && (!EXT_IRQ0_PIN_N || USB_ACTIVITY) |=> !pdown_q) else $error("power-down not left");
    a_wake_no_reset: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [R16]
        wake_pend_q && !wd_rst_q |-> !INT_RESET) else $error("reset raised on wake path");
endmodule : fsw_top
`default_nettype wire

/* test/fail_safe_watchdog_unit_test.sv */
// self-checking bench for the fail-safe watchdog unit
`timescale 1ns/1ps
`default_nettype none
module fail_safe_watchdog_unit_test;
    import fsw_pkg::*;
    // ==========================================================
    // signals
    localparam int FIN = 20; // short final reset phase keeps the run brief
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic slow = 1'b0;
    logic irq0_n = 1'b1;
    logic usb = 1'b0;
    logic rd_phase = 1'b0;
    logic [31:0] hrdata;
    logic hrdy, hresp, osc_stop, rc_sel, int_rst, wake, irq;
    logic [15:0] wvec;
    logic [31:0] lf = 32'hFA5E;
    logic [31:0] qv[$];
    logic [31:0] qm[$];
    int num_errors = 0;
    int n_checks = 0;
    always #12.5 clk = ~clk;
    fsw_top #(.FINAL_CYC(FIN)) DUT (.CLK_SYS(clk), .RESET_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .MAIN_OSC_SLOW(slow),
        .EXT_IRQ0_PIN_N(irq0_n), .USB_ACTIVITY(usb), .OSC_STOP(osc_stop), .RC_CLK_SEL(rc_sel),
        .INT_RESET(int_rst), .WAKE_IRQ(wake), .WAKE_VECTOR(wvec), .IRQ(irq));
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // bounded wait, so a stuck design cannot hang the run
    task automatic wait_lv(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_lv
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rd_phase <= !w;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd_phase <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        qv.push_back(v & m);
        qm.push_back(m);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    task automatic do_reset();
        int n;
        @(posedge clk);
        rst_n <= 1'b0;
        cyc(12);
        chk(int_rst, 1'b1);
        rst_n <= 1'b1;
        wait_lv(int_rst, 1'b0, 100, n);
        chk(n >= FIN && n <= FIN + 6, 1'b1);
    endtask : do_reset
    // ==========================================================
    // read monitor: oldest note against the data phase
    always @(posedge clk) begin
        if (rd_phase) begin
            chk(hrdata & qm.pop_front(), qv.pop_front());
            chk(hresp, 1'b0);
        end
    end
    initial begin
        #500000;
        num_errors++;
        test_done();
    end
    // ==========================================================
    // tests
    initial begin
        int n;
        logic [6:0] rl;
        do_reset();
        rd(FSW_OFF_IRQ_STAT, 32'h0, 32'hFFFFFFFF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        for (int p = 0; p < 2; p++) begin
            lf = lfsr(lf);
            rl = lf[6:0];
            wr(FSW_OFF_RELOAD, {lf[31:8], p[0], rl});
            wr(FSW_OFF_CTRL, 32'h2);
            wr(FSW_OFF_CTRL, 32'h1);
            wr(FSW_OFF_CTRL, 32'h2);
            rd(FSW_OFF_COUNT, {rl, 8'h00}, 32'h7F00);
            cyc(300);
            rd(FSW_OFF_COUNT, {rl, p[0] ? 8'h00 : 8'h18}, 32'h7FF8);
            wr(FSW_OFF_CTRL, 32'h1);
            wr(FSW_OFF_CTRL, 32'h0);
            rd(FSW_OFF_STATUS, 32'h2, 32'h2);
            wr(FSW_OFF_CTRL, 32'h2);
            rd(FSW_OFF_COUNT, {rl, p[0] ? 8'h00 : 8'h10}, 32'h7FF0);
        end
        $display("test prescale and refresh done");
        wr(FSW_OFF_IRQ_MASK, 32'h1);
        wr(FSW_OFF_RELOAD, 32'h7F);
        wr(FSW_OFF_CTRL, 32'h1);
        wr(FSW_OFF_CTRL, 32'h2);
        wait_lv(int_rst, 1'b1, 3200, n);
        chk(n > 3000 && n < 3200, 1'b1);
        cyc(1);
        chk(int_rst, 1'b0);
        cyc(2);
        chk(irq, 1'b1);
        rd(FSW_OFF_STATUS, 32'h1, 32'h3);
        rd(FSW_OFF_IRQ_STAT, 32'h1, 32'h1);
        cyc(2);
        chk(irq, 1'b0);
        $display("test overflow done");
        wr(FSW_OFF_RELOAD, 32'h30);
        wr(FSW_OFF_CTRL, 32'h2);
        wr(FSW_OFF_CTRL, 32'h1);
        wr(FSW_OFF_CTRL, 32'h2);
        wr(FSW_OFF_CTRL, 32'h4);
        cyc(300);
        rd(FSW_OFF_COUNT, 32'h3000, 32'h7FF0);
        $display("test idle done");
        slow <= 1'b1;
        cyc(3);
        chk(rc_sel, 1'b1);
        chk(int_rst, 1'b1);
        chk(irq, 1'b0);
        rd(FSW_OFF_IRQ_STAT, 32'h2, 32'h2);
        slow <= 1'b0;
        wait_lv(int_rst, 1'b0, 100, n);
        chk(n >= FIN && n <= FIN + 6, 1'b1);
        chk(rc_sel, 1'b0);
        do_reset();
        rd(FSW_OFF_STATUS, 32'h0, 32'h1);
        $display("test oscillator monitor done");
        wr(FSW_OFF_RELOAD, 32'h2A);
        for (int s = 0; s < 2; s++) begin
            wr(FSW_OFF_CTRL, 32'h8);
            wait_lv(osc_stop, 1'b1, 10, n);
            chk(osc_stop, 1'b1);
            if (s == 0) begin
                irq0_n <= 1'b0;
            end else begin
                usb <= 1'b1;
            end
            cyc(2);
            irq0_n <= 1'b1;
            usb <= 1'b0;
            wait_lv(wake, 1'b1, 200, n);
            chk(n >= FIN && n <= FIN + 6, 1'b1);
            chk(wake, 1'b1);
            chk(wvec, 16'h007B);
            chk(osc_stop, 1'b0);
            chk(int_rst, 1'b0);
            rd(FSW_OFF_RELOAD, 32'h2A, 32'hFF);
        end
        $display("test power-down done");
        test_done();
    end
endmodule : fail_safe_watchdog_unit_test
`default_nettype wire
